// [rtl/fsp_pkg.sv]
package fsp_pkg;
	// Opcodes
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_ERASE = 8'h52;
	localparam logic [7:0] OP_BLK_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE2 = 8'h60;
	localparam logic [7:0] OP_SECUR_ERASE = 8'h44;
	localparam logic [7:0] OP_SECUR_PROG = 8'h42;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_FOUR_ON = 8'h38;
	localparam logic [7:0] OP_FOUR_OFF = 8'hff;
	// Field positions, low byte
	localparam int WL_POS = 1;
	localparam int RANGE_POS = 2;
	localparam int TOPBOT_POS = 5;
	localparam int GRAN_POS = 6;
	localparam int GUARD_POS = 7;
	// Field positions, mid byte
	localparam int LOCK_POS = 0;
	localparam int QUAD_POS = 1;
	localparam int SLOCK_POS = 3;
	localparam int INVERT_POS = 6;
	localparam int SUSP_POS = 7;
	// Field positions, high byte
	localparam int DRIVE_POS = 5;
	// Values after reset
	localparam logic [2:0] RANGE_RST = 3'h0;
	localparam logic [2:0] SLOCK_RST = 3'h0;
	localparam logic [1:0] DRIVE_RST = 2'h3;
	localparam logic [5:0] SYNC_RST = 6'h20;
	// Array geometry
	localparam logic [23:0] ARRAY_TOP = 24'h0fffff;
	localparam logic [23:0] FULL_TOP = 24'hffffff;
	localparam logic [23:0] SECTOR_BYTES = 24'h001000;
	localparam logic [23:0] BLOCK_BYTES = 24'h010000;
	localparam logic [23:0] PAGE_MASK = 24'h0000ff;
	localparam logic [23:0] SECTOR_MASK = 24'h000fff;
	localparam logic [23:0] HALF_MASK = 24'h007fff;
	localparam logic [23:0] BLOCK_MASK = 24'h00ffff;
	// Drive strength in percent
	localparam logic [6:0] DRIVE_100 = 7'h64;
	localparam logic [6:0] DRIVE_75 = 7'h4b;
	localparam logic [6:0] DRIVE_50 = 7'h32;
	localparam logic [6:0] DRIVE_25 = 7'h19;
	typedef enum logic [2:0] {
		FS_IDLE = 3'b001,
		FS_SHIFT = 3'b010,
		FS_EXEC = 3'b100
	} fsp_frame_t;
	typedef enum logic [2:0] {
		OPK_PAGE = 3'h0,
		OPK_SECTOR = 3'h1,
		OPK_HALF = 3'h2,
		OPK_BLOCK = 3'h3,
		OPK_CHIP = 3'h4,
		OPK_SECUR_ERASE = 3'h5,
		OPK_SECUR_PROG = 3'h6
	} fsp_opkind_t;
endpackage : fsp_pkg

// [rtl/fsp_prot_if.sv]
`timescale 1ns/1ps
// Protection settings and request window to the range checker
interface fsp_prot_if;
	logic [2:0] range_sel;
	logic top_bottom_select;
	logic sector_granularity;
	logic invert_protection;
	logic [23:0] req_start;
	logic [23:0] req_end;
	logic hit;
	modport owner (
		output range_sel, top_bottom_select, sector_granularity,
		output invert_protection, req_start, req_end,
		input hit
	);
	modport range_side (
		input range_sel, top_bottom_select, sector_granularity,
		input invert_protection, req_start, req_end,
		output hit
	);
endinterface : fsp_prot_if

// [rtl/fsp_sync.sv]
`timescale 1ns/1ps
module fsp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q;
	////////////////////////////////////////////////////////////
	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			meta_q <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule : fsp_sync

// [rtl/fsp_range_chk.sv]
`timescale 1ns/1ps
module fsp_range_chk
	import fsp_pkg::*;
(
	fsp_prot_if.range_side prot
);
	logic [23:0] unit;
	logic [23:0] size;
	logic [1:0] shamt;
	logic none;
	logic full;
	logic [23:0] lo;
	logic [23:0] hi;
	////////////////////////////////////////////////////////////
	// Decode the protected window; purely combinational
	always_comb begin
		unit = prot.sector_granularity ? SECTOR_BYTES : BLOCK_BYTES;
		none = (prot.range_sel == 3'h0);
		if (prot.sector_granularity) begin
			full = (prot.range_sel[2:1] == 2'h3);
			shamt = prot.range_sel[2] ? 2'h3 : 2'(prot.range_sel - 3'h1);
		end else begin
			full = (prot.range_sel > 3'h4);
			shamt = 2'(prot.range_sel - 3'h1);
		end
		size = unit << shamt;
		// Top end when selector is 0, bottom when 1
		if (!prot.top_bottom_select) begin
			lo = ARRAY_TOP - size + 24'h000001;
			hi = ARRAY_TOP;
		end else begin
			lo = 24'h000000;
			hi = size - 24'h000001;
		end
		if (full) begin
			lo = 24'h000000;
			hi = FULL_TOP;
		end
		// Inverted mode protects the other part of the array
		if (prot.invert_protection) begin
			if (none || full) begin
				none = full;
				lo = 24'h000000;
				hi = FULL_TOP;
			end else if (!prot.top_bottom_select) begin
				hi = lo - 24'h000001;
				lo = 24'h000000;
			end else begin
				lo = size;
				hi = ARRAY_TOP;
			end
		end
		// Any overlap with the request is a hit
		prot.hit = !none && (prot.req_start <= hi) && (prot.req_end >= lo);
	end
endmodule : fsp_range_chk

// [rtl/fsp_status_prot.sv]
`timescale 1ns/1ps
module fsp_status_prot
	import fsp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic [3:0] data_line_in,
	output logic [7:0] status_low_out,
	output logic [7:0] status_mid_out,
	output logic [7:0] status_high_out,
	output logic four_wire_command_mode_out,
	output logic guard_pin_func_out,
	output logic pause_pin_func_out,
	output logic quad_data_lines_out,
	output logic [6:0] drive_pct_out,
	output logic [2:0] secur_area_ro_out,
	output logic op_go_out,
	output logic [2:0] op_kind_out,
	output logic [23:0] op_start_out,
	output logic [23:0] op_end_out,
	output logic refused_out
);
	////////////////////////////////////////////////////////////
	// Declarations
	logic cs_n_s;
	logic sclk_s;
	logic [3:0] io_s;
	logic sclk_d_q;
	logic cs_n_d_q;
	logic sclk_rise;
	logic cs_fall;
	logic cs_rise;
	fsp_frame_t state_q;
	fsp_frame_t state_d;
	logic [7:0] sh_q;
	logic [2:0] bit_cnt_q;
	logic [2:0] byte_cnt_q;
	logic byte_done;
	logic [7:0] byte_val;
	logic [7:0] op_q;
	logic [7:0] b1_q;
	logic [7:0] b2_q;
	logic [7:0] b3_q;
	logic [23:0] addr;
	logic exec;
	logic write_latch_flag_q;
	logic [2:0] range_sel_q;
	logic top_bottom_select_q;
	logic sector_granularity_q;
	logic status_guard_mode_q;
	logic status_lock_q;
	logic quad_enable_flag_q;
	logic [2:0] security_lock_q;
	logic invert_protection_q;
	logic suspend_flag_q;
	logic four_wire_command_mode_q;
	logic [1:0] drive_strength_q;
	logic is_stwr;
	logic guard_low;
	logic sw_ok;
	logic pe_cmd;
	logic need_addr;
	logic secur_op;
	fsp_opkind_t kind;
	logic [23:0] req_lo;
	logic [23:0] req_hi;
	logic secur_locked;
	logic pe_ok;
	fsp_prot_if u_prot();

	////////////////////////////////////////////////////////////
	// Pin synchronisers: chip select, serial clock, data lines
	fsp_sync #(
		.W(6),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.d_in({spi_cs_n_in, spi_sclk_in, data_line_in}),
		.q_out({cs_n_s, sclk_s, io_s})
	);

	// Edge history, taken from the synchronised copies only
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			sclk_d_q <= 1'b0;
			cs_n_d_q <= 1'b1;
		end else begin
			sclk_d_q <= sclk_s;
			cs_n_d_q <= cs_n_s;
		end
	end

	// Edge detects; serial clock must stay well below sys clock
	assign sclk_rise = sclk_s && !sclk_d_q;
	assign cs_fall = !cs_n_s && cs_n_d_q;
	assign cs_rise = cs_n_s && !cs_n_d_q;

	////////////////////////////////////////////////////////////
	// Frame sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			FS_IDLE: begin
				if (cs_fall) begin
					state_d = FS_SHIFT;
				end
			end
			FS_SHIFT: begin
				if (cs_rise) begin
					state_d = FS_EXEC;
				end
			end
			FS_EXEC: begin
				state_d = FS_IDLE;
			end
			default: begin
				state_d = FS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state_q <= FS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////
	// Shifter: one bit per edge, or a nibble in four-wire mode
	assign byte_done = four_wire_command_mode_q ? (bit_cnt_q == 3'h4) : (bit_cnt_q == 3'h7);
	assign byte_val = four_wire_command_mode_q ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			sh_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 3'h0;
		end else if (cs_fall) begin
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 3'h0;
		end else if (state_q == FS_SHIFT && sclk_rise && !cs_n_s) begin
			sh_q <= byte_val;
			if (four_wire_command_mode_q) begin
				bit_cnt_q <= bit_cnt_q + 3'h4;
			end else begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end
			// Saturate; later data bytes are not needed here
			if (byte_done && byte_cnt_q != 3'h7) begin
				byte_cnt_q <= byte_cnt_q + 3'h1;
			end
		end
	end

	// Opcode and the first three bytes after it
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			op_q <= 8'h00;
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			b3_q <= 8'h00;
		end else if (state_q == FS_SHIFT && sclk_rise && !cs_n_s && byte_done) begin
			case (byte_cnt_q)
				3'h0: begin
					op_q <= byte_val;
				end
				3'h1: begin
					b1_q <= byte_val;
				end
				3'h2: begin
					b2_q <= byte_val;
				end
				3'h3: begin
					b3_q <= byte_val;
				end
				default: begin
					op_q <= op_q;
				end
			endcase
		end
	end

	assign addr = {b1_q, b2_q, b3_q};

	////////////////////////////////////////////////////////////
	// Command qualification
	// A frame ending mid-byte is dropped whole
	assign exec = (state_q == FS_EXEC) && (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0);
	assign is_stwr = exec && (op_q == OP_STAT_WR);

	// Guard pin counts only when it is not a data line
	assign guard_low = status_guard_mode_q && !quad_enable_flag_q && !io_s[2];
	assign sw_ok = is_stwr && write_latch_flag_q && !status_lock_q && !guard_low && (byte_cnt_q >= 3'h2);

	// Program and erase decode with their address windows
	always_comb begin
		pe_cmd = 1'b1;
		need_addr = 1'b1;
		secur_op = 1'b0;
		kind = OPK_PAGE;
		req_lo = addr;
		req_hi = addr | PAGE_MASK;
		case (op_q)
			OP_PAGE_PROG, OP_QUAD_PROG: begin
				kind = OPK_PAGE;
			end
			OP_SECT_ERASE: begin
				kind = OPK_SECTOR;
				req_lo = addr & ~SECTOR_MASK;
				req_hi = addr | SECTOR_MASK;
			end
			OP_HALF_ERASE: begin
				kind = OPK_HALF;
				req_lo = addr & ~HALF_MASK;
				req_hi = addr | HALF_MASK;
			end
			OP_BLK_ERASE: begin
				kind = OPK_BLOCK;
				req_lo = addr & ~BLOCK_MASK;
				req_hi = addr | BLOCK_MASK;
			end
			OP_CHIP_ERASE, OP_CHIP_ERASE2: begin
				kind = OPK_CHIP;
				need_addr = 1'b0;
				req_lo = 24'h000000;
				req_hi = ARRAY_TOP;
			end
			OP_SECUR_ERASE: begin
				kind = OPK_SECUR_ERASE;
				secur_op = 1'b1;
			end
			OP_SECUR_PROG: begin
				kind = OPK_SECUR_PROG;
				secur_op = 1'b1;
			end
			default: begin
				pe_cmd = 1'b0;
			end
		endcase
	end

	// Security area index sits in address bits 13:12
	always_comb begin
		case (addr[13:12])
			2'h1: begin
				secur_locked = security_lock_q[0];
			end
			2'h2: begin
				secur_locked = security_lock_q[1];
			end
			2'h3: begin
				secur_locked = security_lock_q[2];
			end
			default: begin
				secur_locked = 1'b1;
			end
		endcase
	end

	// Range checker sees live settings and the request
	assign u_prot.range_sel = range_sel_q;
	assign u_prot.top_bottom_select = top_bottom_select_q;
	assign u_prot.sector_granularity = sector_granularity_q;
	assign u_prot.invert_protection = invert_protection_q;
	assign u_prot.req_start = req_lo;
	assign u_prot.req_end = req_hi;

	fsp_range_chk u_chk (
		.prot(u_prot)
	);

	assign pe_ok = exec && pe_cmd && (!need_addr || byte_cnt_q >= 3'h4) && write_latch_flag_q
		&& (secur_op ? !secur_locked : !u_prot.hit);

	////////////////////////////////////////////////////////////
	// Write latch flag
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			write_latch_flag_q <= 1'b0;
		end else if (exec && op_q == OP_WR_ENABLE) begin
			write_latch_flag_q <= 1'b1;
		end else if (exec && (op_q == OP_WR_DISABLE || op_q == OP_STAT_WR || pe_cmd)) begin
			write_latch_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// Low status byte fields; reset stands for power-up defaults
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			range_sel_q <= RANGE_RST;
			top_bottom_select_q <= 1'b0;
			sector_granularity_q <= 1'b0;
			status_guard_mode_q <= 1'b0;
		end else if (sw_ok) begin
			range_sel_q <= b1_q[RANGE_POS +: 3];
			top_bottom_select_q <= b1_q[TOPBOT_POS];
			sector_granularity_q <= b1_q[GRAN_POS];
			status_guard_mode_q <= b1_q[GUARD_POS];
		end
	end

	// Mid byte fields, only when the frame carried that byte
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			status_lock_q <= 1'b0;
			quad_enable_flag_q <= 1'b0;
			security_lock_q <= SLOCK_RST;
			invert_protection_q <= 1'b0;
		end else if (sw_ok && byte_cnt_q >= 3'h3) begin
			status_lock_q <= b2_q[LOCK_POS];
			quad_enable_flag_q <= b2_q[QUAD_POS] || four_wire_command_mode_q;
			security_lock_q <= security_lock_q | b2_q[SLOCK_POS +: 3];
			invert_protection_q <= b2_q[INVERT_POS];
		end
	end

	// High byte; other bits there are reserved and dropped
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			drive_strength_q <= DRIVE_RST;
		end else if (sw_ok && byte_cnt_q >= 3'h4) begin
			drive_strength_q <= b3_q[DRIVE_POS +: 2];
		end
	end

	////////////////////////////////////////////////////////////
	// Suspend flag
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			suspend_flag_q <= 1'b0;
		end else if (exec && op_q == OP_SUSPEND) begin
			suspend_flag_q <= 1'b1;
		end else if (exec && op_q == OP_RESUME) begin
			suspend_flag_q <= 1'b0;
		end
	end

	// Four-wire command mode; entry ignored without quad enable
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			four_wire_command_mode_q <= 1'b0;
		end else if (exec && op_q == OP_FOUR_ON && quad_enable_flag_q) begin
			four_wire_command_mode_q <= 1'b1;
		end else if (exec && op_q == OP_FOUR_OFF) begin
			four_wire_command_mode_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// Accepted operation hand-off, one-cycle pulse with window
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			op_go_out <= 1'b0;
			op_kind_out <= 3'h0;
			op_start_out <= 24'h000000;
			op_end_out <= 24'h000000;
			refused_out <= 1'b0;
		end else begin
			op_go_out <= pe_ok;
			refused_out <= (is_stwr && !sw_ok) || (exec && pe_cmd && !pe_ok);
			if (pe_ok) begin
				op_kind_out <= kind;
				op_start_out <= req_lo;
				op_end_out <= req_hi;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Registered status views; busy and reserved bits read zero
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			status_low_out <= 8'h00;
			status_mid_out <= 8'h00;
			status_high_out <= 8'h00;
		end else begin
			status_low_out <= {status_guard_mode_q, sector_granularity_q, top_bottom_select_q,
				range_sel_q, write_latch_flag_q, 1'b0};
			status_mid_out <= {suspend_flag_q, invert_protection_q, security_lock_q, 1'b0,
				quad_enable_flag_q, status_lock_q};
			status_high_out <= {1'b0, drive_strength_q, 5'h00};
		end
	end

	// Pin function selection and derived controls
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			four_wire_command_mode_out <= 1'b0;
			guard_pin_func_out <= 1'b1;
			pause_pin_func_out <= 1'b1;
			quad_data_lines_out <= 1'b0;
			secur_area_ro_out <= 3'h0;
		end else begin
			four_wire_command_mode_out <= four_wire_command_mode_q;
			guard_pin_func_out <= !quad_enable_flag_q;
			pause_pin_func_out <= !quad_enable_flag_q;
			quad_data_lines_out <= quad_enable_flag_q;
			secur_area_ro_out <= security_lock_q;
		end
	end

	// Drive strength decode for read outputs
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			drive_pct_out <= DRIVE_25;
		end else begin
			case (drive_strength_q)
				2'h0: begin
					drive_pct_out <= DRIVE_100;
				end
				2'h1: begin
					drive_pct_out <= DRIVE_75;
				end
				2'h2: begin
					drive_pct_out <= DRIVE_50;
				end
				default: begin
					drive_pct_out <= DRIVE_25;
				end
			endcase
		end
	end
endmodule : fsp_status_prot

// [verif/fsp_status_prot_asserts.sv]
`timescale 1ns/1ps
// Watches the status and request outputs of the protection block
module fsp_status_prot_asserts
	import fsp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] status_low_out,
	input wire logic [7:0] status_mid_out,
	input wire logic [7:0] status_high_out,
	input wire logic four_wire_command_mode_out,
	input wire logic guard_pin_func_out,
	input wire logic pause_pin_func_out,
	input wire logic quad_data_lines_out,
	input wire logic [6:0] drive_pct_out,
	input wire logic [2:0] secur_area_ro_out,
	input wire logic op_go_out,
	input wire logic [2:0] op_kind_out,
	input wire logic [23:0] op_start_out,
	input wire logic [23:0] op_end_out,
	input wire logic refused_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	////////////////
	// Requests: the status copy lags the latch by one edge
	go_ref_excl_a:
		assert property (!(op_go_out && refused_out)) else $error("accept and refuse at once");
	go_latch_a:
		assert property (op_go_out |-> status_low_out[WL_POS] ##1 !status_low_out[WL_POS])
			else $error("accept without latch or latch kept");
	ref_latch_a:
		assert property (refused_out |=> !status_low_out[WL_POS]) else $error("latch kept after refusal");
	sector_span_a:
		assert property (op_go_out && op_kind_out == OPK_SECTOR |-> op_end_out - op_start_out == SECTOR_MASK)
			else $error("sector window wrong");
	block_span_a:
		assert property (op_go_out && op_kind_out == OPK_BLOCK |-> op_end_out - op_start_out == BLOCK_MASK)
			else $error("block window wrong");
	////////////////
	// Status fields
	lock_freeze_a:
		assert property ($past(status_mid_out[LOCK_POS]) |-> $stable(status_low_out[7:2]))
			else $error("protection changed while locked");
	secur_sticky_a:
		assert property ($past(rstn_in) |-> (secur_area_ro_out & $past(secur_area_ro_out)) == $past(secur_area_ro_out))
			else $error("security lock cleared");
	quad_hold_a:
		assert property (four_wire_command_mode_out |-> status_mid_out[QUAD_POS]) else $error("quad enable dropped");
	pin_func_a:
		assert property (guard_pin_func_out == !quad_data_lines_out && pause_pin_func_out == guard_pin_func_out)
			else $error("pin functions disagree with quad enable");
	drive_map_a:
		assert property ($past(rstn_in) && $past(rstn_in, 2) && $stable(status_high_out) && $stable(drive_pct_out)
			|-> drive_pct_out == (status_high_out[6:5] == 2'h0 ? DRIVE_100 : status_high_out[6:5] == 2'h1 ? DRIVE_75
			: status_high_out[6:5] == 2'h2 ? DRIVE_50 : DRIVE_25)) else $error("drive percent wrong");
endmodule : fsp_status_prot_asserts
bind fsp_status_prot fsp_status_prot_asserts i_fsp_status_prot_asserts (
	.sys_clk_in,
	.rstn_in,
	.status_low_out,
	.status_mid_out,
	.status_high_out,
	.four_wire_command_mode_out,
	.guard_pin_func_out,
	.pause_pin_func_out,
	.quad_data_lines_out,
	.drive_pct_out,
	.secur_area_ro_out,
	.op_go_out,
	.op_kind_out,
	.op_start_out,
	.op_end_out,
	.refused_out
);

// [verif/fsp_host_model.sv]
`timescale 1ns/1ps
// Host side of the link; its clock stands still low between frames
module fsp_host_model (
	input wire logic clk_in,
	input wire logic guard_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] io_out
);
	logic [3:0] io_q = 4'hd;
	logic quad_q = 1'b0;
	initial sclk_out = 1'b0;
	initial cs_n_out = 1'b1;
	// Guard pin belongs to the bench unless the latest frame was sent in nibbles
	assign io_out = {io_q[3], quad_q ? io_q[2] : guard_in, io_q[1:0]};
	////////////////
	// Frame of nb bits, MSB first, half clock period of 4 system cycles
	task automatic send(input logic [31:0] v, input int nb, input bit q);
		// Lines change off the sampling edge, never on it
		@(posedge clk_in) #2;
		quad_q = q;
		cs_n_out = 1'b0;
		for (int i = 0; i < nb; i += (q ? 4 : 1)) begin
			io_q = q ? v[31 - i -: 4] : {2'h3, ~io_q[1], v[31 - i]};
			repeat (4) @(posedge clk_in) #2;
			sclk_out = 1'b1;
			repeat (4) @(posedge clk_in) #2;
			sclk_out = 1'b0;
		end
		repeat (4) @(posedge clk_in) #2;
		cs_n_out = 1'b1;
		io_q = ~io_q; // Released lines must not keep the last bit
		repeat (6) @(posedge clk_in) #2;
	endtask : send
endmodule : fsp_host_model

// [verif/fsp_status_prot_tb.sv]
`timescale 1ns/1ps
module fsp_status_prot_tb
	import fsp_pkg::*;
;
	typedef struct packed {
		logic we;
		logic [5:0] nb;
		logic [31:0] v;
		logic go;
		logic rf;
		logic [7:0] lo;
	} fsp_row_t;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic guard = 1'b1;
	logic sclk, cs_n, four_wire, guard_fn, pause_fn, quad_fn, go, refused;
	logic [3:0] io;
	logic [7:0] st_lo, st_mid, st_hi;
	logic [6:0] drive;
	logic [2:0] sec_ro, kind;
	logic [23:0] op_start, op_end;
	int num_errors = 0;
	int total_checks = 0;
	int go_cnt = 0;
	int rf_cnt = 0;
	int dgo, drf;
	logic [6:0] exp_drv [4] = '{DRIVE_100, DRIVE_75, DRIVE_50, DRIVE_25};
	// Write enable marks a row that needs the latch set first
	fsp_row_t rows [30] = '{
		{1'h0,6'h08,32'h06000000,1'h0,1'h0,8'h02},
		{1'h0,6'h08,32'h04000000,1'h0,1'h0,8'h00},
		{1'h0,6'h20,32'h02000000,1'h0,1'h1,8'h00},
		{1'h1,6'h20,32'h020f0000,1'h1,1'h0,8'h00},
		{1'h1,6'h10,32'h01040000,1'h0,1'h0,8'h04},
		{1'h1,6'h20,32'h200f0000,1'h0,1'h1,8'h04},
		{1'h1,6'h20,32'hd80e0000,1'h1,1'h0,8'h04},
		{1'h1,6'h08,32'hc7000000,1'h0,1'h1,8'h04},
		{1'h1,6'h10,32'h01240000,1'h0,1'h0,8'h24},
		{1'h1,6'h20,32'h200f0000,1'h1,1'h0,8'h24},
		{1'h1,6'h20,32'h20000000,1'h0,1'h1,8'h24},
		{1'h1,6'h10,32'h01440000,1'h0,1'h0,8'h44},
		{1'h1,6'h20,32'h200fe000,1'h1,1'h0,8'h44},
		{1'h1,6'h20,32'h020ff0ff,1'h0,1'h1,8'h44},
		{1'h1,6'h10,32'h01140000,1'h0,1'h0,8'h14},
		{1'h1,6'h20,32'h02000000,1'h0,1'h1,8'h14},
		{1'h1,6'h18,32'h015c4000,1'h0,1'h0,8'h5c},
		{1'h1,6'h20,32'h20000000,1'h1,1'h0,8'h5c},
		{1'h1,6'h18,32'h01444000,1'h0,1'h0,8'h44},
		{1'h1,6'h20,32'h200ff000,1'h1,1'h0,8'h44},
		{1'h1,6'h20,32'h200fe000,1'h0,1'h1,8'h44},
		{1'h1,6'h18,32'h01000000,1'h0,1'h0,8'h00},
		{1'h1,6'h07,32'h04000000,1'h0,1'h0,8'h02},
		{1'h0,6'h1f,32'h02000000,1'h0,1'h0,8'h02},
		{1'h0,6'h08,32'h04000000,1'h0,1'h0,8'h00},
		{1'h1,6'h20,32'h320a0000,1'h1,1'h0,8'h00},
		{1'h1,6'h20,32'h52080000,1'h1,1'h0,8'h00},
		{1'h1,6'h08,32'h60000000,1'h1,1'h0,8'h00},
		{1'h1,6'h20,32'h42000000,1'h0,1'h1,8'h00},
		{1'h1,6'h20,32'h44002000,1'h1,1'h0,8'h00}
	};
	always #12.5 sys_clk = ~sys_clk;
	fsp_status_prot i_fsp_status_prot (
		.sys_clk_in(sys_clk),
		.rstn_in(rstn),
		.spi_sclk_in(sclk),
		.spi_cs_n_in(cs_n),
		.data_line_in(io),
		.status_low_out(st_lo),
		.status_mid_out(st_mid),
		.status_high_out(st_hi),
		.four_wire_command_mode_out(four_wire),
		.guard_pin_func_out(guard_fn),
		.pause_pin_func_out(pause_fn),
		.quad_data_lines_out(quad_fn),
		.drive_pct_out(drive),
		.secur_area_ro_out(sec_ro),
		.op_go_out(go),
		.op_kind_out(kind),
		.op_start_out(op_start),
		.op_end_out(op_end),
		.refused_out(refused)
	);
	fsp_host_model i_fsp_host_model (
		.clk_in(sys_clk),
		.guard_in(guard),
		.sclk_out(sclk),
		.cs_n_out(cs_n),
		.io_out(io)
	);
	// Pulses last one cycle, so count them as they pass; unknown counts as a pulse
	always @(posedge sys_clk) begin
		go_cnt += (go !== 1'b0);
		rf_cnt += (refused !== 1'b0);
	end
	////////////////
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Fixed settle time: the result shows about five cycles after select rises
	task automatic cmd(input logic [31:0] v, input int nb, input bit q = 1'b0);
		int g0, r0;
		g0 = go_cnt;
		r0 = rf_cnt;
		i_fsp_host_model.send(v, nb, q);
		repeat (8) @(posedge sys_clk);
		dgo = go_cnt - g0;
		drf = rf_cnt - r0;
	endtask : cmd
	task automatic wst(input logic [31:0] v, input int nb, input bit q = 1'b0);
		cmd(32'h06000000, 8, q);
		cmd(v, nb, q);
	endtask : wst
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	////////////////
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		$display("ERROR watchdog expired");
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#2 rstn = 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("drive", DRIVE_25, drive);
		foreach (rows[i]) begin
			if (rows[i].we) cmd(32'h06000000, 8);
			cmd(rows[i].v, rows[i].nb);
			chk("go", rows[i].go, dgo[23:0]);
			chk("refused", rows[i].rf, drf[23:0]);
			chk("low", rows[i].lo, st_lo);
		end
		chk("kind", OPK_SECUR_ERASE, kind);
		// Program window and kind
		wst(32'h020a1234, 32);
		chk("kind", OPK_PAGE, kind);
		chk("start", 24'h0a1234, op_start);
		chk("end", 24'h0a12ff, op_end);
		// Guard pin only matters in guard mode
		wst(32'h01800000, 16);
		#2 guard = 1'b0;
		wst(32'h01840000, 16);
		chk("refused", 1'h1, drf[23:0]);
		chk("low", 8'h80, st_lo);
		#2 guard = 1'b1;
		wst(32'h01000000, 16);
		chk("low", 8'h00, st_lo);
		#2 guard = 1'b0;
		wst(32'h01040000, 16);
		chk("low", 8'h04, st_lo);
		#2 guard = 1'b1;
		for (int c = 0; c < 4; c++) begin
			wst({8'h01, 16'h0000, 1'h0, c[1:0], 5'h00}, 32);
			chk("drive", exp_drv[c], drive);
		end
		// Four-wire mode needs quad enable and keeps it
		cmd(32'h38000000, 8);
		chk("four", 1'h0, four_wire);
		wst(32'h01000200, 24);
		chk("qlines", 1'h1, quad_fn);
		chk("guardfn", 1'h0, guard_fn);
		chk("pausefn", 1'h0, pause_fn);
		cmd(32'h38000000, 8);
		chk("four", 1'h1, four_wire);
		wst(32'h01000000, 24, 1'b1);
		chk("quad", 1'h1, st_mid[QUAD_POS]);
		cmd(32'hff000000, 8, 1'b1);
		wst(32'h01000000, 24);
		chk("guardfn", 1'h1, guard_fn);
		chk("pausefn", 1'h1, pause_fn);
		// Security locks are set-only
		wst(32'h01000800, 24);
		wst(32'h01000000, 24);
		chk("secro", 3'h1, sec_ro);
		wst(32'h42001000, 32);
		chk("refused", 1'h1, drf[23:0]);
		cmd(32'h75000000, 8);
		chk("suspend", 1'h1, st_mid[SUSP_POS]);
		cmd(32'h7a000000, 8);
		chk("suspend", 1'h0, st_mid[SUSP_POS]);
		// Lock holds until a power cycle, modelled by reset
		wst(32'h01000100, 24);
		wst(32'h01040000, 16);
		chk("refused", 1'h1, drf[23:0]);
		#2 rstn = 1'b0;
		repeat (8) @(posedge sys_clk);
		#2 rstn = 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("mid", 8'h00, st_mid);
		chk("high", 8'h60, st_hi);
		wst(32'h01040000, 16);
		chk("low", 8'h04, st_lo);
		print_verdict();
	end
endmodule : fsp_status_prot_tb
